// ### src/dwc_write_decoder.v
// Purpose: Decode and execute the write group of serial debug commands.
// Assumes: A bit front end hands received bits MSB first, one per pulse.
// Notes:   Ack pulse drives the debug pin; status byte goes back as a byte.
`include "dwc_consts.vh"

module dwc_write_decoder (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        halted,
    input  wire        bit_vld,
    input  wire        bit_val,
    output reg         pin_out,
    output reg         pin_oe_n,
    output reg  [7:0]  tx_byte,
    output reg         tx_vld,
    output reg         core_wr,
    output reg  [5:0]  core_reg_sel,
    output reg  [31:0] core_wr_data,
    input  wire        core_done,
    output reg         dreg_wr,
    output reg  [4:0]  dreg_num,
    output reg  [31:0] dreg_data,
    output reg         mem_wr,
    output reg  [23:0] mem_addr,
    output reg  [1:0]  mem_size,
    output reg  [1:0]  mem_type,
    output reg  [2:0]  mem_mod,
    output reg  [31:0] mem_data,
    input  wire        mem_done,
    output wire [31:0] xst_out,
    output wire [31:0] sts2_out,
    output wire [31:0] sts3_out,
    output wire [31:0] attr_out,
    output reg         cmd_illegal,
    output wire        busy
);

    localparam [2:0] ST_CMD  = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_DATA = 3'h2;
    localparam [2:0] ST_EXEC = 3'h3;
    localparam [2:0] ST_WAIT = 3'h4;
    localparam [2:0] ST_ACKL = 3'h5;
    localparam [2:0] ST_ACKS = 3'h6;

    localparam [2:0] K_NONE = 3'h0;
    localparam [2:0] K_MEM  = 3'h1;
    localparam [2:0] K_CREG = 3'h2;
    localparam [2:0] K_RN   = 3'h3;
    localparam [2:0] K_DREG = 3'h4;
    localparam [2:0] K_BX   = 3'h5;
    localparam [2:0] K_B2   = 3'h6;
    localparam [2:0] K_B3   = 3'h7;

    reg  [2:0]  st_r;
    reg  [2:0]  kind_r;
    reg  [7:0]  op_r;
    reg  [7:0]  shift_r;
    reg  [2:0]  bitc_r;
    reg  [2:0]  left_r;
    reg  [23:0] addr_r;
    reg  [31:0] data_r;
    reg  [5:0]  delay_r;
    reg  [4:0]  ackc_r;
    reg  [31:0] xst_r;
    reg  [31:0] sts2_r;
    reg  [31:0] sts3_r;
    reg  [31:0] attr_r;
    reg  [2:0]  kind_nxt;
    reg  [2:0]  dbytes_nxt;
    wire        tick;
    wire [7:0]  byte_in;
    wire        byte_done;
    wire        rx_open;
    wire        ws;

    assign xst_out  = xst_r;
    assign sts2_out = sts2_r;
    assign sts3_out = sts3_r;
    assign attr_out = attr_r;
    assign busy     = (st_r != ST_CMD);
    assign ws       = op_r[0];

    ////////////////////////////////////////////////////////////////////
    // Debug clock enable
    dwc_tick_gen #(
        .DIV (`DWC_DBG_DIV)
    ) u_tick (
        .clk    (clk),
        .arst_n (arst_n),
        .tick_r (tick)
    );

    ////////////////////////////////////////////////////////////////////
    // Bit assembly, MSB first; bits that arrive during execute, wait or ack are ignored
    assign rx_open   = (st_r == ST_CMD) || (st_r == ST_ADDR) || (st_r == ST_DATA);
    assign byte_in   = {shift_r[6:0], bit_val};
    assign byte_done = rx_open && bit_vld && (bitc_r == `DWC_LAST_BIT);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_r <= 8'h00;
            bitc_r  <= 3'h0;
        end else if (rx_open && bit_vld) begin
            shift_r <= byte_in;
            bitc_r  <= bitc_r + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Opcode decode: kind and operand length from the command byte
    always @* begin
        kind_nxt   = K_NONE;
        dbytes_nxt = `DWC_LONG_BYTES;
        if (byte_in[7:4] == `DWC_MEM_HI && !byte_in[1] && byte_in[3:2] != 2'h3) begin
            kind_nxt = K_MEM;
            case (byte_in[3:2])
                `DWC_SZ_BYTE: dbytes_nxt = `DWC_ONE_BYTE;
                `DWC_SZ_WORD: dbytes_nxt = `DWC_TWO_BYTES;
                default:      dbytes_nxt = `DWC_LONG_BYTES;
            endcase
        end else if (byte_in[7:4] == `DWC_RN_HI) begin
            kind_nxt = K_RN;
        end else if (byte_in[7:5] == `DWC_DREG_HI) begin
            kind_nxt = K_DREG;
        end else if (byte_in[7:5] == `DWC_CREG_HI) begin
            kind_nxt = K_CREG;
        end else if (byte_in == `DWC_XST_BYTE_CMD) begin
            kind_nxt   = K_BX;
            dbytes_nxt = `DWC_ONE_BYTE;
        end else if (byte_in == `DWC_STS2_BYTE_CMD) begin
            kind_nxt   = K_B2;
            dbytes_nxt = `DWC_ONE_BYTE;
        end else if (byte_in == `DWC_STS3_BYTE_CMD) begin
            kind_nxt   = K_B3;
            dbytes_nxt = `DWC_ONE_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command sequencer: collect, execute, wait, acknowledge
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r         <= ST_CMD;
            kind_r       <= K_NONE;
            op_r         <= 8'h00;
            left_r       <= 3'h0;
            addr_r       <= 24'h00_0000;
            data_r       <= `DWC_RST_32;
            delay_r      <= 6'h00;
            ackc_r       <= 5'h00;
            xst_r        <= `DWC_RST_32;
            sts2_r       <= `DWC_RST_32;
            sts3_r       <= `DWC_RST_32;
            attr_r       <= `DWC_RST_32;
            pin_out      <= 1'b1;
            pin_oe_n     <= 1'b1;
            tx_byte      <= 8'h00;
            tx_vld       <= 1'b0;
            core_wr      <= 1'b0;
            core_reg_sel <= 6'h00;
            core_wr_data <= `DWC_RST_32;
            dreg_wr      <= 1'b0;
            dreg_num     <= 5'h00;
            dreg_data    <= `DWC_RST_32;
            mem_wr       <= 1'b0;
            mem_addr     <= 24'h00_0000;
            mem_size     <= 2'h0;
            mem_type     <= 2'h0;
            mem_mod      <= 3'h0;
            mem_data     <= `DWC_RST_32;
            cmd_illegal  <= 1'b0;
        end else begin
            tx_vld      <= 1'b0;
            dreg_wr     <= 1'b0;
            cmd_illegal <= 1'b0;
            // Minimum ack delay counts from the end of the last bit
            if (st_r == ST_EXEC || st_r == ST_WAIT) begin
                if (tick && delay_r != `DWC_ACK_MIN_WAIT)
                    delay_r <= delay_r + 6'h01;
            end else begin
                delay_r <= 6'h00;
            end
            case (st_r)
                ST_CMD: begin
                    if (byte_done) begin
                        op_r   <= byte_in;
                        kind_r <= kind_nxt;
                        left_r <= dbytes_nxt;
                        data_r <= `DWC_RST_32;
                        if (kind_nxt == K_NONE) begin
                            cmd_illegal <= 1'b1;
                        end else if (kind_nxt == K_MEM) begin
                            left_r <= `DWC_ADDR_BYTES;
                            data_r <= {29'h0000_0000, dbytes_nxt};
                            st_r   <= ST_ADDR;
                        end else begin
                            st_r <= ST_DATA;
                        end
                    end
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        addr_r <= {addr_r[15:0], byte_in};
                        left_r <= left_r - 3'h1;
                        if (left_r == `DWC_ONE_BYTE) begin
                            left_r <= data_r[2:0];
                            data_r <= `DWC_RST_32;                   // Stashed length must not leak into data
                            st_r   <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (byte_done) begin
                        data_r <= {data_r[23:0], byte_in};
                        left_r <= left_r - 3'h1;
                        if (left_r == `DWC_ONE_BYTE)
                            st_r <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    st_r <= ST_WAIT;
                    case (kind_r)
                        K_MEM: begin
                            mem_wr   <= 1'b1;
                            mem_size <= op_r[3:2];
                            mem_data <= data_r;
                            mem_type <= attr_r[`DWC_TYPE_MSB:`DWC_TYPE_LSB];
                            mem_mod  <= attr_r[`DWC_MOD_MSB:`DWC_MOD_LSB];
                            if (op_r[3:2] == `DWC_SZ_WORD)
                                mem_addr <= {addr_r[23:1], 1'b0};
                            else if (op_r[3:2] == `DWC_SZ_LONG)
                                mem_addr <= {addr_r[23:2], 2'h0};
                            else
                                mem_addr <= addr_r;
                        end
                        K_CREG, K_RN: begin
                            if (halted) begin
                                core_wr      <= 1'b1;
                                core_wr_data <= data_r;
                                if (kind_r == K_CREG)
                                    core_reg_sel <= {`DWC_GRP_CREG, op_r[3:0]};
                                else
                                    core_reg_sel <= {`DWC_GRP_RN, op_r[3:0]};
                            end else begin
                                cmd_illegal <= 1'b1;
                            end
                        end
                        K_DREG: begin
                            case (op_r[4:0])
                                `DWC_DN_XST:
                                    xst_r[`DWC_LOW_MSB:0] <= data_r[`DWC_LOW_MSB:0];
                                `DWC_DN_STS2:
                                    sts2_r[`DWC_LOW_MSB:0] <= data_r[`DWC_LOW_MSB:0];
                                `DWC_DN_STS3:
                                    sts3_r[`DWC_LOW_MSB:0] <= data_r[`DWC_LOW_MSB:0];
                                `DWC_DN_ATTR:
                                    attr_r <= data_r;
                                default: begin
                                    dreg_wr   <= 1'b1;
                                    dreg_num  <= op_r[4:0];
                                    dreg_data <= data_r;
                                end
                            endcase
                        end
                        K_BX: xst_r[`DWC_TOP_MSB:`DWC_TOP_LSB] <= data_r[7:0];
                        K_B2: sts2_r[`DWC_TOP_MSB:`DWC_TOP_LSB] <= data_r[7:0];
                        K_B3: sts3_r[`DWC_TOP_MSB:`DWC_TOP_LSB] <= data_r[7:0];
                        default: cmd_illegal <= 1'b1;
                    endcase
                end
                ST_WAIT: begin
                    // Drop requests as core or memory answers; ack only after both
                    if (mem_done)
                        mem_wr <= 1'b0;
                    if (core_done)
                        core_wr <= 1'b0;
                    if (!mem_wr && !core_wr && tick && delay_r == `DWC_ACK_MIN_WAIT) begin
                        st_r     <= ST_ACKL;
                        ackc_r   <= 5'h00;
                        pin_out  <= 1'b0;
                        pin_oe_n <= 1'b0;
                    end
                end
                ST_ACKL: begin
                    if (tick) begin
                        ackc_r <= ackc_r + 5'h01;
                        if (ackc_r == `DWC_ACK_LOW_TICKS - 5'h01) begin
                            st_r    <= ST_ACKS;
                            pin_out <= 1'b1;
                        end
                    end
                end
                ST_ACKS: begin
                    if (tick) begin
                        pin_oe_n <= 1'b1;
                        st_r     <= ST_CMD;
                        if (kind_r == K_MEM && ws) begin
                            tx_byte <= xst_r[`DWC_TOP_MSB:`DWC_TOP_LSB];
                            tx_vld  <= 1'b1;
                        end
                    end
                end
                default: st_r <= ST_CMD;
            endcase
        end
    end

endmodule

// ### src/dwc_consts.vh
// Purpose: Constants of the debug write command decoder.
// Assumes: Included by dwc_write_decoder.v and dwc_tick_gen.v only.
// Notes:   Command codes, register numbers, field positions and counts.
`ifndef DWC_CONSTS_VH
`define DWC_CONSTS_VH

////////////////////////////////////////////////////////////////////////
// Command codes and masks
`define DWC_MEM_HI          4'h1
`define DWC_RN_HI           4'h4
`define DWC_DREG_HI         3'h4
`define DWC_CREG_HI         3'h6
`define DWC_XST_BYTE_CMD    8'h2d
`define DWC_STS2_BYTE_CMD   8'h2e
`define DWC_STS3_BYTE_CMD   8'h2f
`define DWC_SZ_BYTE         2'h0
`define DWC_SZ_WORD         2'h1
`define DWC_SZ_LONG         2'h2

////////////////////////////////////////////////////////////////////////
// Register group encodings
`define DWC_GRP_CREG        2'h3
`define DWC_GRP_RN          2'h1

////////////////////////////////////////////////////////////////////////
// Debug register numbers held locally
`define DWC_DN_XST          5'h01
`define DWC_DN_STS2         5'h02
`define DWC_DN_STS3         5'h03
`define DWC_DN_ATTR         5'h05

////////////////////////////////////////////////////////////////////////
// Field layout
`define DWC_LOW_MSB         23
`define DWC_TOP_MSB         31
`define DWC_TOP_LSB         24
`define DWC_MOD_MSB         2
`define DWC_MOD_LSB         0
`define DWC_TYPE_MSB        4
`define DWC_TYPE_LSB        3
`define DWC_RST_32          32'h0000_0000

////////////////////////////////////////////////////////////////////////
// Byte counts and last bit index
`define DWC_ADDR_BYTES      3'h3
`define DWC_LONG_BYTES      3'h4
`define DWC_ONE_BYTE        3'h1
`define DWC_TWO_BYTES       3'h2
`define DWC_LAST_BIT        3'h7

////////////////////////////////////////////////////////////////////////
// Debug clock timing: divider in clk cycles, ack delay and low phase in debug clock ticks
`define DWC_DBG_DIV         8'h10
`define DWC_DIV_W           8
`define DWC_ACK_MIN_WAIT    6'h20
`define DWC_ACK_LOW_TICKS   5'h10

`endif

// ### src/dwc_tick_gen.v
// Purpose: Debug clock enable, one clk cycle wide every DIV cycles.
// Assumes: Single clk domain, asynchronous active-low reset.
// Notes:   Divider value is fixed by the constants header.
`include "dwc_consts.vh"

module dwc_tick_gen #(
    parameter [`DWC_DIV_W-1:0] DIV = `DWC_DBG_DIV
) (
    input  wire clk,
    input  wire arst_n,
    output reg  tick_r
);

    reg [`DWC_DIV_W-1:0] cnt_r;

    ////////////////////////////////////////////////////////////////////
    // Free-running divider; the pulse never stalls so delays stay honest
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r  <= {`DWC_DIV_W{1'b0}};
            tick_r <= 1'b0;
        end else if (cnt_r == DIV - 1'b1) begin
            cnt_r  <= {`DWC_DIV_W{1'b0}};
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

endmodule

// ### dv/dwc_write_decoder_properties.sv
// Purpose: Concurrent checks on the ports of the debug write decoder.
// Assumes: Debug tick is clk/16, so ack phases are counted in clk cycles.
// Notes:   Bound into every decoder instance at the foot of this file.
module dwc_checker (
    input wire        clk,
    input wire        arst_n,
    input wire        bit_vld,
    input wire        halted,
    input wire        pin_out,
    input wire        pin_oe_n,
    input wire [7:0]  tx_byte,
    input wire        tx_vld,
    input wire        core_wr,
    input wire [5:0]  core_reg_sel,
    input wire        mem_wr,
    input wire        mem_done,
    input wire [23:0] mem_addr,
    input wire [31:0] mem_data,
    input wire [1:0]  mem_size,
    input wire [1:0]  mem_type,
    input wire [2:0]  mem_mod,
    input wire [31:0] xst_out,
    input wire [31:0] attr_out,
    input wire        busy
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [8:0]  low_r;
    reg [11:0] gap_r;
    ////////////////////////////////////////////////////////////////////////
    // Low phase length and distance from the last bit; gap saturates so it never wraps
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_r <= 9'h000;
            gap_r <= 12'hfff;
        end else begin
            low_r <= pin_oe_n ? 9'h000 : (pin_out ? low_r : low_r + 9'h001);
            gap_r <= bit_vld ? 12'h000 : ((gap_r == 12'hfff) ? gap_r : gap_r + 12'h001);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////
    AST_ACK_LOW: assert property ($rose(pin_out) && !pin_oe_n |-> low_r == 9'h100)
        else $error("ack low phase is not 16 ticks");
    AST_SPEEDUP: assert property ($rose(pin_out) && !pin_oe_n |-> ##15 (pin_out && !pin_oe_n) ##1 pin_oe_n)
        else $error("speedup pulse is not one tick");
    AST_ACK_DELAY: assert property ($fell(pin_oe_n) |-> gap_r >= 12'h1f0)
        else $error("ack started too soon after the last bit");
    AST_IDLE_HIGH: assert property (pin_oe_n |-> pin_out)
        else $error("pin drive value low while released");
    AST_ACK_AFTER: assert property (!pin_oe_n |-> busy && !mem_wr && !core_wr)
        else $error("ack while a request is still open");
    AST_ALIGN: assert property (mem_wr |-> mem_size == 2'h0 || (mem_size == 2'h1 && !mem_addr[0])
        || (mem_size == 2'h2 && mem_addr[1:0] == 2'h0)) else $error("memory address not aligned");
    AST_ATTR: assert property ($rose(mem_wr) |-> mem_type == attr_out[4:3] && mem_mod == attr_out[2:0])
        else $error("memory attributes differ from attribute register");
    AST_MEM_HOLD: assert property (mem_wr && !mem_done |=> mem_wr && $stable(mem_addr) && $stable(mem_data))
        else $error("memory request dropped or changed early");
    AST_CORE_HALT: assert property ($rose(core_wr) |-> halted && core_reg_sel[4])
        else $error("core write while running or with bad group");
    AST_STATUS: assert property (tx_vld |-> tx_byte == xst_out[31:24] && $past(pin_oe_n) == 1'b0)
        else $error("status byte wrong or not right after ack");
endmodule

bind dwc_write_decoder dwc_checker u_dwc_checker (.clk(clk), .arst_n(arst_n), .bit_vld(bit_vld), .halted(halted),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .tx_byte(tx_byte), .tx_vld(tx_vld), .core_wr(core_wr),
    .core_reg_sel(core_reg_sel), .mem_wr(mem_wr), .mem_done(mem_done), .mem_addr(mem_addr), .mem_data(mem_data),
    .mem_size(mem_size), .mem_type(mem_type), .mem_mod(mem_mod), .xst_out(xst_out), .attr_out(attr_out), .busy(busy));

// ### dv/dwc_host_model.sv
// Purpose: Host pod and core or memory responder facing the decoder.
// Assumes: Done answers after a random wait of 0 to 15 clocks.
// Notes:   The released data line toggles every clock, whatever the last bit was.
module dwc_host_model (
    input  wire clk,
    input  wire arst_n,
    output reg  bit_vld,
    output wire bit_val,
    input  wire core_wr,
    output reg  core_done,
    input  wire mem_wr,
    output reg  mem_done
);
    timeunit 1ns;
    timeprecision 1ps;
    reg       bit_r;
    reg       noise_r;
    reg [3:0] core_cnt_r;
    reg [3:0] mem_cnt_r;
    assign bit_val = bit_vld ? bit_r : noise_r;
    initial begin
        bit_vld = 1'b0;
        bit_r   = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Done after a random wait, so prompt and slow answers both occur
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            noise_r    <= 1'b0;
            core_done  <= 1'b0;
            mem_done   <= 1'b0;
            core_cnt_r <= 4'h3;
            mem_cnt_r  <= 4'h0;
        end else begin
            noise_r   <= ~noise_r;
            core_done <= 1'b0;
            mem_done  <= 1'b0;
            if (core_wr && !core_done) begin
                core_cnt_r <= core_cnt_r - 4'h1;
                if (core_cnt_r == 4'h0) begin
                    core_done  <= 1'b1;
                    core_cnt_r <= 4'($urandom);
                end
            end
            if (mem_wr && !mem_done) begin
                mem_cnt_r <= mem_cnt_r - 4'h1;
                if (mem_cnt_r == 4'h0) begin
                    mem_done  <= 1'b1;
                    mem_cnt_r <= 4'($urandom);
                end
            end
        end
    end
    // One byte, MSB first, one bit per clock
    task automatic send_byte(input [7:0] b);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            @(posedge clk);
            bit_vld <= 1'b1;
            bit_r   <= b[i];
        end
    endtask
    task automatic bus_idle;
        @(posedge clk);
        bit_vld <= 1'b0;
    endtask
endmodule

// ### dv/test_debug_write_command_decoder.sv
// Purpose: Self-checking bench of the debug write command decoder.
// Assumes: 250 MHz clk, four reset cycles, bits come from the host model.
// Notes:   Expectations queue up; a monitor retires one per observed event.
module test_debug_write_command_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [3:0] MAC_STAT_N  = 4'h4; // Control numbers of the MAC block, a plain choice
    localparam [3:0] MAC_ACCUM_N = 4'h6;
    logic        clk, arst_n, halted, bit_vld, bit_val, pin_out, pin_oe_n, tx_vld, core_wr, core_done;
    logic        dreg_wr, mem_wr, mem_done, cmd_illegal, busy, core_p, mem_p;
    logic [7:0]  tx_byte;
    logic [5:0]  core_reg_sel;
    logic [4:0]  dreg_num;
    logic [23:0] mem_addr;
    logic [1:0]  mem_size, mem_type;
    logic [2:0]  mem_mod;
    logic [31:0] core_wr_data, dreg_data, mem_data, xst_out, sts2_out, sts3_out, attr_out;
    logic [66:0] exp_q[$];
    integer      n_fail, total_checks;
    dwc_write_decoder u_dwc_write_decoder (.clk(clk), .arst_n(arst_n), .halted(halted), .bit_vld(bit_vld),
        .bit_val(bit_val), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .tx_byte(tx_byte), .tx_vld(tx_vld),
        .core_wr(core_wr), .core_reg_sel(core_reg_sel), .core_wr_data(core_wr_data), .core_done(core_done),
        .dreg_wr(dreg_wr), .dreg_num(dreg_num), .dreg_data(dreg_data), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_size(mem_size), .mem_type(mem_type), .mem_mod(mem_mod), .mem_data(mem_data), .mem_done(mem_done),
        .xst_out(xst_out), .sts2_out(sts2_out), .sts3_out(sts3_out), .attr_out(attr_out),
        .cmd_illegal(cmd_illegal), .busy(busy));
    dwc_host_model u_dwc_host_model (.clk(clk), .arst_n(arst_n), .bit_vld(bit_vld), .bit_val(bit_val),
        .core_wr(core_wr), .core_done(core_done), .mem_wr(mem_wr), .mem_done(mem_done));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input [66:0] seen, input [66:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // An event with nothing queued compares against unknown and fails
    task automatic retire(input [66:0] seen);
        check(seen, exp_q.size() ? exp_q.pop_front() : {67{1'bx}});
    endtask
    // Monitor: each result seen at the ports takes the oldest expectation
    always @(posedge clk) begin
        core_p <= core_wr;
        mem_p  <= mem_wr;
        if (arst_n) begin
            if (core_wr && !core_p) retire({3'h1, 26'h0, core_reg_sel, core_wr_data});
            if (dreg_wr) retire({3'h2, 27'h0, dreg_num, dreg_data});
            if (mem_wr && !mem_p) retire({3'h3, 1'b0, mem_addr, mem_size, mem_type, mem_mod, mem_data});
            if (tx_vld) retire({3'h4, 56'h0, tx_byte});
            if (cmd_illegal) retire({3'h5, 64'h0});
        end
    end
    // Command byte, na address bytes, nd data bytes, then wait out the ack
    task automatic cmd(input [7:0] op, input [23:0] adr, input int na, input [31:0] d, input int nd);
        int k;
        u_dwc_host_model.send_byte(op);
        for (k = na - 1; k >= 0; k--) u_dwc_host_model.send_byte(adr[8*k +: 8]);
        for (k = nd - 1; k >= 0; k--) u_dwc_host_model.send_byte(d[8*k +: 8]);
        u_dwc_host_model.bus_idle;
        repeat (3) @(negedge clk);
        k = 0;
        while (busy !== 1'b0 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        check(67'(busy), 67'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d, bv, dm;
        logic [23:0] a;
        logic [7:0]  sb, xb;
        logic [3:0]  n;
        logic [1:0]  sz;
        int          i;
        arst_n = 1'b0;
        halted = 1'b1;
        n_fail = 0;
        total_checks = 0;
        void'($urandom(32'hc277));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        check({pin_oe_n, pin_out, xst_out | sts2_out | sts3_out | attr_out}, {2'h3, 32'h0});
        // Halted: rounding off twice through the MAC status, then the accumulator
        for (i = 0; i < 3; i++) begin
            n = (i < 2) ? MAC_STAT_N : MAC_ACCUM_N;
            d = (i < 2) ? 32'h0 : $urandom;
            exp_q.push_back({3'h1, 26'h0, 2'h3, n, d});
            cmd(8'hc0 + n, 24'h0, 0, d, 4);
        end
        for (i = 0; i < 2; i++) begin
            n = 4'($urandom);
            d = $urandom;
            exp_q.push_back({3'h1, 26'h0, 2'h1, n, d});
            cmd(8'h40 + n, 24'h0, 0, d, 4);
        end
        // Running: control and general writes are refused, debug writes go through
        @(posedge clk) halted <= 1'b0;
        for (i = 0; i < 2; i++) begin
            exp_q.push_back({3'h5, 64'h0});
            cmd((i == 0) ? 8'hc3 : 8'h47, 24'h0, 0, $urandom, 4);
        end
        n = 4'($urandom);
        d = $urandom;
        exp_q.push_back({3'h2, 27'h0, 1'b1, n, d});
        cmd(8'h90 + n, 24'h0, 0, d, 4);
        for (i = 1; i < 4; i++) begin
            sb = $urandom;
            if (i == 1) xb = sb;
            cmd(8'h2c + i, 24'h0, 0, sb, 1);
            d = $urandom;
            cmd(8'h80 + i, 24'h0, 0, d, 4);
            check((i == 1) ? xst_out : (i == 2) ? sts2_out : sts3_out, {sb, d[23:0]});
        end
        bv = $urandom;
        cmd(8'h85, 24'h0, 0, bv, 4);
        check(attr_out, bv);
        // Every size, plain and with status, from an unaligned address
        sb = xb; // Status byte as last written, not read back from the design
        for (i = 0; i < 6; i++) begin
            sz = 2'(i / 2);
            a = $urandom | 24'h3;
            d = $urandom;
            dm = (sz == 2'h2) ? d : d & ((32'h1 << (8 << sz)) - 32'h1);
            exp_q.push_back({3'h3, 1'b0, a & ~((24'h1 << sz) - 24'h1), sz, bv[4:3], bv[2:0], dm});
            if (i % 2) exp_q.push_back({3'h4, 56'h0, sb});
            cmd(8'h10 + 4 * sz + i % 2, a, 3, d, 1 << sz);
        end
        // Unknown opcode is refused without ack; the next command still works
        @(posedge clk) halted <= 1'b1;
        exp_q.push_back({3'h5, 64'h0});
        cmd(8'h00, 24'h0, 0, 32'h0, 0);
        sb = $urandom;
        cmd(8'h2d, 24'h0, 0, sb, 1);
        check(xst_out[31:24], sb);
        check(exp_q.size(), 67'h0);
        results;
    end
    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        n_fail = n_fail + 1;
        results;
    end
endmodule
